/* File: design/tsc_mem.sv */
`timescale 1ns/1ps
// Small single-clock memory: one microport side, one internal write side
module tsc_mem (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstN,
    // Microport side
    input wire logic [tsc_pkg::MEM_AW-1:0] uAddr,
    input wire logic uWe,
    input wire logic [tsc_pkg::DATA_W-1:0] uWdata,
    output logic [tsc_pkg::DATA_W-1:0] uRdata,
    // Internal write side
    input wire logic iWe,
    input wire logic [tsc_pkg::MEM_AW-1:0] iAddr,
    input wire logic [tsc_pkg::DATA_W-1:0] iWdata
);

    typedef struct packed {
        logic [tsc_pkg::MEM_DEPTH-1:0][tsc_pkg::DATA_W-1:0] words;
        logic [tsc_pkg::DATA_W-1:0] rdata;
    } tsc_mem_state_t;

    tsc_mem_state_t q;
    tsc_mem_state_t nxt_q;

    // Internal write lands after the microport one, so it wins a collision
    always_comb begin
        nxt_q = q;
        nxt_q.rdata = q.words[uAddr];
        if (uWe) begin
            nxt_q.words[uAddr] = uWdata;
        end
        if (iWe) begin
            nxt_q.words[iAddr] = iWdata;
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            q <= '0;
        end else begin
            q <= nxt_q;
        end
    end

    assign uRdata = q.rdata;

endmodule

/* File: design/tsc_pkg.sv */
package tsc_pkg;

    // ----------------------------------------
    // Register map and field layout
    // ----------------------------------------
    localparam logic [14:0] OFS_CONTROL = 15'h0000;
    localparam logic [14:0] OFS_BLOCK_PROG = 15'h0001;
    localparam int ADDR_MEM_BIT = 14;
    localparam int MODE_LSB = 13;
    localparam int BIT_DISCRIM_EN = 10;
    localparam int BIT_WIDTH_SEL = 8;
    localparam int BIT_EDGE_SEL = 6;
    localparam int BIT_INVERT = 5;
    localparam int BIT_ARM = 4;
    localparam int BIT_STANDBY = 3;
    localparam int SEL_LSB = 0;
    localparam int BIT_BP_START = 0;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] CONTROL_WMASK = 16'he57b;
    localparam logic BP_START_RESET = 1'b0;

    // ----------------------------------------
    // Field encodings
    // ----------------------------------------
    localparam logic [2:0] MODE_WIDE = 3'h7;
    localparam logic [2:0] MODE_NARROW = 3'h0;
    localparam logic [1:0] SEL_LOCAL_CONN = 2'h0;
    localparam logic [1:0] SEL_BACK_CONN = 2'h1;
    localparam logic [1:0] SEL_LOCAL_DATA = 2'h2;
    localparam logic [1:0] SEL_BACK_DATA = 2'h3;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int FP8_NARROW_NS = 122;
    localparam int FP8_WIDE_NS = 244;
    localparam int FP16_NARROW_NS = 61;
    localparam int FP16_WIDE_NS = 122;
    localparam logic [2:0] FP8_NARROW_CYC = 3'((FP8_NARROW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [2:0] FP8_WIDE_CYC = 3'((FP8_WIDE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [2:0] FP16_NARROW_CYC = 3'((FP16_NARROW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [2:0] FP16_WIDE_CYC = 3'((FP16_WIDE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [9:0] FRAME_LAST_EDGE = 10'h3ff;
    localparam logic [9:0] TOL_NARROW = 10'h001;
    localparam logic [9:0] TOL_WIDE = 10'h002;

    // ----------------------------------------
    // Memories and pins
    // ----------------------------------------
    localparam int MEM_AW = 4;
    localparam int MEM_DEPTH = 16;
    localparam int DATA_W = 16;
    localparam int NUM_MEMS = 4;
    localparam logic [3:0] MEM_LAST = 4'hf;
    localparam int NUM_PINS = 7;
    localparam int PIN_CS = 0;
    localparam int PIN_RW = 1;
    localparam int PIN_ODE = 2;
    localparam int PIN_BST = 3;
    localparam int PIN_LST = 4;
    localparam int PIN_FP = 5;
    localparam int PIN_CLK = 6;
    localparam logic [6:0] PIN_RESET = 7'h03;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_READ = 3'b010,
        ST_ACK = 3'b100
    } tsc_bus_state_t;

endpackage

/* File: design/tsc_switch_control.sv */
`timescale 1ns/1ps
// Overview of operation
// [R1] Discriminator enable tolerates inconsistent frame boundaries
// [R2] Source drives frame pulse per width field
// [R3] Output frame pulses sized by width field
// [R4] Edge select picks falling or rising edge
// [R5] Output clocks follow or invert input polarity
// [R6] Arm field gates connection memory block programming
// [R7] Serial outputs need drive pin and standby
// [R8] Disabled outputs driven high or released per pin
// [R9] Memory select steers later microport accesses
// [R10] Reserved bits zero; fields reset to zero
// [R11] Mode 000 narrow, 111 wide; else reserved
// [R12] Clearing arm or start aborts programming
// [R13] Data memories ignore microport writes
// [R14] Width and polarity change at frame boundary
module tsc_switch_control (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Microport
    input wire logic chipSelect_n,
    input wire logic readWrite,
    input wire logic [14:0] address,
    input wire logic [15:0] writeData,
    output logic [15:0] readData,
    output logic readDataOe,
    output logic dataAck_n,
    // Frame timing
    input wire logic clockIn8m,
    input wire logic framePulseIn8m,
    output logic clockOut8m,
    output logic clockOut16m,
    output logic framePulseOut8m,
    output logic framePulseOut16m,
    // Output gating pins
    input wire logic outputDriveEnablePin,
    input wire logic backplaneOutStatePin,
    input wire logic localOutStatePin,
    // Switching datapath
    input wire logic [31:0] backplaneStreamData,
    input wire logic [31:0] localStreamData,
    input wire logic [1:0] dataMemWrite,
    input wire logic [3:0] dataMemAddr,
    input wire logic [15:0] dataMemData,
    // Serial outputs
    output logic [31:0] backplaneSerialOut,
    output logic [31:0] backplaneSerialOe,
    output logic [31:0] localSerialOut,
    output logic [31:0] localSerialOe,
    // Status
    output logic blockProgramBusy
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [tsc_pkg::NUM_PINS-1:0] syncA;
        logic [tsc_pkg::NUM_PINS-1:0] syncB;
        logic [tsc_pkg::NUM_PINS-1:0] syncC;
        logic [tsc_pkg::NUM_PINS-1:0] pinLvl;
        tsc_pkg::tsc_bus_state_t st;
        logic [15:0] ctrl;
        logic bpStart;
        logic bpRun;
        logic [3:0] bpIdx;
        logic [1:0] memSel;
        logic [15:0] dataOut;
        logic dataOe;
        logic ackN;
        logic clkPrev;
        logic [9:0] edgeCnt;
        logic bnd;
        logic widthSel;
        logic invert;
        logic [2:0] fp8Cnt;
        logic [2:0] fp16Cnt;
        logic clk16Tog;
        logic clk8Out;
        logic clk16Out;
        logic fp8Out;
        logic fp16Out;
        logic [31:0] bOut;
        logic [31:0] bOe;
        logic [31:0] lOut;
        logic [31:0] lOe;
    } tsc_ctl_state_t;

    tsc_ctl_state_t q;
    tsc_ctl_state_t nxt_q;
    logic [1:0] rstPipe;
    logic rstN;
    logic [tsc_pkg::NUM_MEMS-1:0] uWe;
    logic [tsc_pkg::NUM_MEMS-1:0] iWe;
    logic [tsc_pkg::NUM_MEMS-1:0][15:0] iWdata;
    logic [tsc_pkg::NUM_MEMS-1:0][15:0] memRdata;
    logic edgeSeen;
    logic fpAccept;
    logic bndNow;
    logic outEnable;
    logic memWrHit;
    logic [9:0] tol;

    // True for the read-only memories
    function automatic logic isDataMem(input logic [1:0] sel);
        isDataMem = (sel == tsc_pkg::SEL_LOCAL_DATA) || (sel == tsc_pkg::SEL_BACK_DATA);
    endfunction

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    // Assertion is immediate, release is two clocks late to avoid recovery hazards
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstN = rstPipe[1];

    // ----------------------------------------
    // Memories
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < tsc_pkg::NUM_MEMS; g++) begin : gen_mem
            // Microport writes into a data memory are dropped
            assign uWe[g] = memWrHit && (q.ctrl[tsc_pkg::SEL_LSB +: 2] == 2'(g)) && !isDataMem(2'(g)); // [R9] [R13]
            if (g < 2) begin : gen_conn
                assign iWe[g] = q.bpRun; // [R6]
                assign iWdata[g] = 16'h0000;
            end else begin : gen_data
                assign iWe[g] = dataMemWrite[g-2];
                assign iWdata[g] = dataMemData;
            end
            tsc_mem u_mem (
                .clk_sys(clk_sys),
                .rstN(rstN),
                .uAddr(address[3:0]),
                .uWe(uWe[g]),
                .uWdata(writeData),
                .uRdata(memRdata[g]),
                .iWe(iWe[g]),
                .iAddr(g < 2 ? q.bpIdx : dataMemAddr),
                .iWdata(iWdata[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // Frame boundary and discriminator
    // ----------------------------------------
    always_comb begin
        edgeSeen = q.ctrl[tsc_pkg::BIT_EDGE_SEL] ? (q.pinLvl[tsc_pkg::PIN_CLK] && !q.clkPrev)
                                                  : (!q.pinLvl[tsc_pkg::PIN_CLK] && q.clkPrev); // [R4]
        // Reserved mode codes fall back to the narrow window
        tol = (q.ctrl[tsc_pkg::MODE_LSB +: 3] == tsc_pkg::MODE_WIDE) ? tsc_pkg::TOL_WIDE : tsc_pkg::TOL_NARROW; // [R11]
        if (!q.ctrl[tsc_pkg::BIT_DISCRIM_EN]) begin
            fpAccept = q.pinLvl[tsc_pkg::PIN_FP]; // [R1]
        end else begin
            // A pulse far from the expected edge is ignored, the flywheel keeps time
            fpAccept = q.pinLvl[tsc_pkg::PIN_FP] && (q.edgeCnt >= tsc_pkg::FRAME_LAST_EDGE - tol); // [R1] [R11]
        end
        bndNow = edgeSeen && (fpAccept || q.edgeCnt == tsc_pkg::FRAME_LAST_EDGE);
        outEnable = q.pinLvl[tsc_pkg::PIN_ODE] && q.ctrl[tsc_pkg::BIT_STANDBY]; // [R7]
        memWrHit = (q.st == tsc_pkg::ST_IDLE) && !q.pinLvl[tsc_pkg::PIN_CS] && !q.pinLvl[tsc_pkg::PIN_RW]
                   && address[tsc_pkg::ADDR_MEM_BIT];
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        nxt_q = q;
        // Pin synchronisers: a change counts once the last two stages agree
        nxt_q.syncA = {clockIn8m, framePulseIn8m, localOutStatePin, backplaneOutStatePin,
                       outputDriveEnablePin, readWrite, chipSelect_n};
        nxt_q.syncB = q.syncA;
        nxt_q.syncC = q.syncB;
        for (int i = 0; i < tsc_pkg::NUM_PINS; i++) begin
            if (q.syncB[i] == q.syncC[i]) begin
                nxt_q.pinLvl[i] = q.syncB[i];
            end
        end

        // Frame timing
        nxt_q.clkPrev = q.pinLvl[tsc_pkg::PIN_CLK];
        nxt_q.bnd = bndNow;
        if (edgeSeen) begin
            nxt_q.edgeCnt = bndNow ? 10'h000 : q.edgeCnt + 10'h001;
        end
        // New width and polarity settings only take effect on a boundary
        if (bndNow) begin
            nxt_q.widthSel = q.ctrl[tsc_pkg::BIT_WIDTH_SEL]; // [R14]
            nxt_q.invert = q.ctrl[tsc_pkg::BIT_INVERT]; // [R14]
            nxt_q.fp8Cnt = q.ctrl[tsc_pkg::BIT_WIDTH_SEL] ? tsc_pkg::FP8_WIDE_CYC : tsc_pkg::FP8_NARROW_CYC; // [R3]
            nxt_q.fp16Cnt = q.ctrl[tsc_pkg::BIT_WIDTH_SEL] ? tsc_pkg::FP16_WIDE_CYC : tsc_pkg::FP16_NARROW_CYC; // [R3]
        end else begin
            nxt_q.fp8Cnt = (q.fp8Cnt != 3'h0) ? q.fp8Cnt - 3'h1 : 3'h0;
            nxt_q.fp16Cnt = (q.fp16Cnt != 3'h0) ? q.fp16Cnt - 3'h1 : 3'h0;
        end
        nxt_q.fp8Out = (q.fp8Cnt != 3'h0);
        nxt_q.fp16Out = (q.fp16Cnt != 3'h0);
        // The fast clock is only a divided stand-in at this sample rate
        nxt_q.clk16Tog = !q.clk16Tog;
        nxt_q.clk8Out = q.pinLvl[tsc_pkg::PIN_CLK] ^ q.invert; // [R5]
        nxt_q.clk16Out = q.clk16Tog ^ q.invert; // [R5]

        // Serial output gating
        nxt_q.bOut = outEnable ? backplaneStreamData : 32'hffffffff; // [R8]
        nxt_q.bOe = outEnable ? 32'hffffffff : {32{q.pinLvl[tsc_pkg::PIN_BST]}}; // [R8]
        nxt_q.lOut = outEnable ? localStreamData : 32'hffffffff; // [R8]
        nxt_q.lOe = outEnable ? 32'hffffffff : {32{q.pinLvl[tsc_pkg::PIN_LST]}}; // [R8]

        // Block programming sweep, finishing clears the start bit
        if (q.bpRun) begin
            nxt_q.bpIdx = q.bpIdx + 4'h1;
            if (q.bpIdx == tsc_pkg::MEM_LAST) begin
                nxt_q.bpRun = 1'b0;
                nxt_q.bpStart = 1'b0;
            end
        end

        // Microport handshake
        case (q.st)
            tsc_pkg::ST_IDLE: begin
                if (!q.pinLvl[tsc_pkg::PIN_CS]) begin
                    nxt_q.memSel = q.ctrl[tsc_pkg::SEL_LSB +: 2]; // [R9]
                    nxt_q.dataOut = 16'h0000;
                    if (q.pinLvl[tsc_pkg::PIN_RW]) begin
                        if (address[tsc_pkg::ADDR_MEM_BIT]) begin
                            nxt_q.st = tsc_pkg::ST_READ;
                        end else begin
                            if (address == tsc_pkg::OFS_CONTROL) begin
                                nxt_q.dataOut = q.ctrl;
                            end else if (address == tsc_pkg::OFS_BLOCK_PROG) begin
                                nxt_q.dataOut = {15'h0000, q.bpStart};
                            end
                            nxt_q.st = tsc_pkg::ST_ACK;
                        end
                    end else begin
                        if (address == tsc_pkg::OFS_CONTROL) begin
                            nxt_q.ctrl = writeData & tsc_pkg::CONTROL_WMASK; // [R10]
                        end else if (address == tsc_pkg::OFS_BLOCK_PROG) begin
                            nxt_q.bpStart = writeData[tsc_pkg::BIT_BP_START]; // [R12]
                            if (writeData[tsc_pkg::BIT_BP_START] && !q.bpStart && q.ctrl[tsc_pkg::BIT_ARM]) begin
                                nxt_q.bpRun = 1'b1; // [R6]
                                nxt_q.bpIdx = 4'h0;
                            end
                        end
                        nxt_q.st = tsc_pkg::ST_ACK;
                    end
                end
            end
            tsc_pkg::ST_READ: begin
                nxt_q.dataOut = memRdata[q.memSel]; // [R9] [R13]
                nxt_q.st = tsc_pkg::ST_ACK;
            end
            tsc_pkg::ST_ACK: begin
                if (q.pinLvl[tsc_pkg::PIN_CS]) begin
                    nxt_q.st = tsc_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_q.st = tsc_pkg::ST_IDLE;
            end
        endcase
        // Abort looks at the values being written, so the sweep never outlives its arm
        if (!nxt_q.ctrl[tsc_pkg::BIT_ARM] || !nxt_q.bpStart) begin
            nxt_q.bpRun = 1'b0; // [R12]
        end
        nxt_q.ackN = !((nxt_q.st == tsc_pkg::ST_ACK) && !q.pinLvl[tsc_pkg::PIN_CS]);
        nxt_q.dataOe = (nxt_q.st == tsc_pkg::ST_ACK) && !q.pinLvl[tsc_pkg::PIN_CS] && q.pinLvl[tsc_pkg::PIN_RW];
    end

    // State register, all fields start at zero except idle pins, bus state, ack and serial output data
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            q <= '0;
            q.syncA <= tsc_pkg::PIN_RESET;
            q.syncB <= tsc_pkg::PIN_RESET;
            q.syncC <= tsc_pkg::PIN_RESET;
            q.pinLvl <= tsc_pkg::PIN_RESET;
            q.st <= tsc_pkg::ST_IDLE;
            q.ctrl <= tsc_pkg::CONTROL_RESET; // [R10]
            q.bpStart <= tsc_pkg::BP_START_RESET;
            q.ackN <= 1'b1;
            q.bOut <= 32'hffffffff;
            q.lOut <= 32'hffffffff;
        end else begin
            q <= nxt_q;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign readData = q.dataOut;
    assign readDataOe = q.dataOe;
    assign dataAck_n = q.ackN;
    assign clockOut8m = q.clk8Out;
    assign clockOut16m = q.clk16Out;
    assign framePulseOut8m = q.fp8Out;
    assign framePulseOut16m = q.fp16Out;
    assign backplaneSerialOut = q.bOut;
    assign backplaneSerialOe = q.bOe;
    assign localSerialOut = q.lOut;
    assign localSerialOe = q.lOe;
    assign blockProgramBusy = q.bpRun;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstN);

    a_backplane_gate: assert property (!q.pinLvl[tsc_pkg::PIN_ODE] |=> // [R7]
        (q.bOut == 32'hffffffff) && (q.bOe == {32{$past(q.pinLvl[tsc_pkg::PIN_BST])}}))
        else $error("backplane outputs not gated while drive pin low");
    a_local_gate: assert property (!q.ctrl[tsc_pkg::BIT_STANDBY] |=> // [R8]
        (q.lOut == 32'hffffffff) && (q.lOe == {32{$past(q.pinLvl[tsc_pkg::PIN_LST])}}))
        else $error("local outputs not gated while standby low");
    a_prog_armed: assert property (q.bpRun |-> q.ctrl[tsc_pkg::BIT_ARM] && q.bpStart) // [R6]
        else $error("block programming runs without arm");
    a_prog_abort: assert property ($fell(q.ctrl[tsc_pkg::BIT_ARM]) || $fell(q.bpStart) |-> !q.bpRun) // [R12]
        else $error("block programming not aborted");
    a_data_readonly: assert property (memWrHit && q.ctrl[tsc_pkg::SEL_LSB +: 2] == tsc_pkg::SEL_LOCAL_DATA // [R13]
        && !dataMemWrite[0] |=> $stable(gen_mem[2].u_mem.q.words))
        else $error("microport write reached a data memory");
    a_fp8_narrow: assert property ($rose(q.fp8Out) && !q.widthSel |-> q.fp8Out [*3] ##1 !q.fp8Out) // [R3]
        else $error("narrow 8m frame pulse width wrong");
    a_fp16_wide: assert property ($rose(q.fp16Out) && q.widthSel |-> q.fp16Out [*3] ##1 !q.fp16Out) // [R3]
        else $error("wide 16m frame pulse width wrong");
    a_clk_polarity: assert property (##1 q.clk8Out == ($past(q.pinLvl[tsc_pkg::PIN_CLK]) ^ $past(q.invert))) // [R5]
        else $error("8m output clock polarity wrong");
    a_bnd_edge: assert property (!q.ctrl[tsc_pkg::BIT_DISCRIM_EN] && edgeSeen && q.pinLvl[tsc_pkg::PIN_FP] // [R1]
        |=> q.bnd && q.edgeCnt == 10'h000)
        else $error("frame pulse at selected edge missed");
    a_settings_hold: assert property ($changed(q.invert) || $changed(q.widthSel) |-> $past(bndNow)) // [R14]
        else $error("frame settings changed off a boundary");

endmodule

/* File: tb/tdm_switch_control_register_tb_top.sv */
`timescale 1ns/1ps
module tdm_switch_control_register_tb_top;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic chipSelect_n, readWrite, readDataOe, dataAck_n;
    logic [14:0] address;
    logic [15:0] writeData, readData, q;
    logic clockIn8m = 1'b0;
    logic framePulseIn8m = 1'b0;
    logic clockOut8m, clockOut16m, framePulseOut8m, framePulseOut16m;
    logic outputDriveEnablePin = 1'b0;
    logic backplaneOutStatePin = 1'b0;
    logic localOutStatePin = 1'b0;
    logic [1:0] dataMemWrite = 2'h0;
    logic [3:0] dataMemAddr = 4'h0;
    logic [15:0] dataMemData = 16'h0000;
    logic [31:0] backplaneSerialOut, backplaneSerialOe, localSerialOut, localSerialOe;
    logic blockProgramBusy, c16;
    int faults, error_cnt = 0, compares = 0, cycles = 0, r8 = 0, r16 = 0, w8 = 0, w16 = 0;
    // Control writes beside their read-back; reserved bits stay zero
    logic [31:0] rows[6] = '{32'h0000_0000, 32'he400_e400, 32'h0001_0001,
                             32'h0002_0002, 32'h0003_0003, 32'h0178_0178};

    always #25 clk_sys = ~clk_sys;

    tsc_switch_control uut (.clk_sys(clk_sys), .reset_n(reset_n), .chipSelect_n(chipSelect_n),
        .readWrite(readWrite), .address(address), .writeData(writeData), .readData(readData),
        .readDataOe(readDataOe), .dataAck_n(dataAck_n), .clockIn8m(clockIn8m),
        .framePulseIn8m(framePulseIn8m), .clockOut8m(clockOut8m), .clockOut16m(clockOut16m),
        .framePulseOut8m(framePulseOut8m), .framePulseOut16m(framePulseOut16m),
        .outputDriveEnablePin(outputDriveEnablePin), .backplaneOutStatePin(backplaneOutStatePin),
        .localOutStatePin(localOutStatePin), .backplaneStreamData(32'h0f0f_3c3c),
        .localStreamData(32'ha5a5_5a5a), .dataMemWrite(dataMemWrite), .dataMemAddr(dataMemAddr),
        .dataMemData(dataMemData), .backplaneSerialOut(backplaneSerialOut),
        .backplaneSerialOe(backplaneSerialOe), .localSerialOut(localSerialOut),
        .localSerialOe(localSerialOe), .blockProgramBusy(blockProgramBusy));

    tsc_cpu_model cpu (.clk_sys(clk_sys), .chipSelect_n(chipSelect_n), .readWrite(readWrite),
        .address(address), .writeData(writeData), .readData(readData), .dataAck_n(dataAck_n),
        .faults(faults));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [14:0] a, input logic [15:0] d);
        logic [15:0] z;
        cpu.xfer(1'b0, a, d, z);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #5;
    endtask

    // One slow input clock period; the pulse straddles the falling edge at step 8
    task automatic per(input int w, input logic i0, input logic i1);
        for (int c = 0; c < 16; c++) begin
            cyc(1);
            clockIn8m = (c < 8);
            framePulseIn8m = (w > 0 && c >= 6 && c < 6 + w);
            if (c == 7) chk(clockOut8m, 32'(1'b1 ^ i0));
            if (c == 15) chk(clockOut8m, 32'(i1));
        end
    endtask

    task automatic finish_test;
        error_cnt += faults;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Width of the last frame pulses seen on each output
    always @(posedge clk_sys) begin
        if (framePulseOut8m === 1'b1) r8++;
        else if (r8 > 0) begin
            w8 = r8;
            r8 = 0;
        end
        if (framePulseOut16m === 1'b1) r16++;
        else if (r16 > 0) begin
            w16 = r16;
            r16 = 0;
        end
    end

    // Read data drive stands with the ack of a read only
    always @(negedge clk_sys) begin
        if (dataAck_n === 1'b0) chk(readDataOe, 32'(readWrite));
    end

    // Hang guard; a full run needs under a thousand cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            finish_test();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        cyc(16);
        chk(dataAck_n, 32'h1);
        reset_n = 1'b1;
        cyc(4);
        cpu.xfer(1'b1, tsc_pkg::OFS_CONTROL, 16'h0000, q);
        chk(q, 32'h0);
        foreach (rows[i]) begin
            wr(tsc_pkg::OFS_CONTROL, rows[i][31:16]);
            cpu.xfer(1'b1, tsc_pkg::OFS_CONTROL, 16'h0000, q);
            chk(q, rows[i][15:0]);
        end
        // Connection memory is read/write
        wr(tsc_pkg::OFS_CONTROL, 16'h0000);
        wr(15'h4005, 16'h1234);
        cpu.xfer(1'b1, 15'h4005, 16'h0000, q);
        chk(q, 32'h1234);
        // Data memories keep what the datapath stored, not the microport write
        for (int m = 0; m < 2; m++) begin
            wr(tsc_pkg::OFS_CONTROL, 16'(2 + m));
            dataMemWrite = 2'(1 << m);
            dataMemAddr = 4'h5;
            dataMemData = 16'h5aa5 ^ 16'(m);
            cyc(1);
            dataMemWrite = 2'h0;
            wr(15'h4005, 16'h0f0f);
            cpu.xfer(1'b1, 15'h4005, 16'h0000, q);
            chk(q, 32'h5aa5 ^ 32'(m));
        end
        // Output gating over every drive pin, standby and backplane state pin combination; local state pin is the inverse
        for (int k = 0; k < 8; k++) begin
            wr(tsc_pkg::OFS_CONTROL, k[0] ? 16'h0008 : 16'h0000);
            outputDriveEnablePin = k[1];
            backplaneOutStatePin = k[2];
            localOutStatePin = ~k[2];
            cyc(8);
            if (!(k[0] && k[1])) begin
                chk(backplaneSerialOe, k[2] ? 32'hffff_ffff : 32'h0);
                chk(localSerialOe, k[2] ? 32'h0 : 32'hffff_ffff);
                if (k[2]) chk(backplaneSerialOut, 32'hffff_ffff);
                else chk(localSerialOut, 32'hffff_ffff);
            end else begin
                chk(backplaneSerialOut, 32'h0f0f_3c3c);
                chk(localSerialOut, 32'ha5a5_5a5a);
                chk(backplaneSerialOe & localSerialOe, 32'hffff_ffff);
            end
        end
        // Start without arm stays idle; with arm the sweep runs and start clears itself
        wr(tsc_pkg::OFS_CONTROL, 16'h0000);
        wr(tsc_pkg::OFS_BLOCK_PROG, 16'h0001);
        chk(blockProgramBusy, 32'h0);
        wr(tsc_pkg::OFS_BLOCK_PROG, 16'h0000);
        wr(tsc_pkg::OFS_CONTROL, 16'h0010);
        wr(tsc_pkg::OFS_BLOCK_PROG, 16'h0001);
        chk(blockProgramBusy, 32'h1);
        cyc(40);
        cpu.xfer(1'b1, tsc_pkg::OFS_BLOCK_PROG, 16'h0000, q);
        chk(q, 32'h0);
        // Dropping arm mid-sweep aborts it, so start is left set
        wr(tsc_pkg::OFS_BLOCK_PROG, 16'h0001);
        chk(blockProgramBusy, 32'h1);
        wr(tsc_pkg::OFS_CONTROL, 16'h0000);
        cpu.xfer(1'b1, tsc_pkg::OFS_BLOCK_PROG, 16'h0000, q);
        chk(q, 32'h1);
        // Frame pulses and output clock polarity, applied only at a boundary
        wr(tsc_pkg::OFS_CONTROL, 16'h0000);
        per(3, 1'b0, 1'b0);
        per(3, 1'b0, 1'b0);
        cyc(8);
        chk(w8, 32'd3);
        chk(w16, 32'd2);
        wr(tsc_pkg::OFS_CONTROL, 16'h0120);
        per(0, 1'b0, 1'b0);
        per(5, 1'b0, 1'b1);
        per(0, 1'b1, 1'b1);
        chk(w8, 32'd5);
        chk(w16, 32'd3);
        // Discriminator on: an early pulse is ignored and polarity holds
        wr(tsc_pkg::OFS_CONTROL, 16'h0400);
        w8 = 0;
        per(3, 1'b1, 1'b1);
        cyc(8);
        chk(w8, 32'd0);
        c16 = clockOut16m;
        cyc(1);
        chk(clockOut16m, 32'(!c16));
        // Reset in mid-run clears the control fields again
        reset_n = 1'b0;
        cyc(2);
        reset_n = 1'b1;
        cyc(4);
        cpu.xfer(1'b1, tsc_pkg::OFS_CONTROL, 16'h0000, q);
        chk(q, 32'h0);
        finish_test();
    end
endmodule

/* File: tb/tsc_cpu_model.sv */
`timescale 1ns/1ps
// Microprocessor on the parallel port
module tsc_cpu_model (
    // Clock
    input wire logic clk_sys,
    // Bus
    output logic chipSelect_n,
    output logic readWrite,
    output logic [14:0] address,
    output logic [15:0] writeData,
    input wire logic [15:0] readData,
    input wire logic dataAck_n,
    // Status
    output int faults
);
    // Idle bus at time zero
    initial begin
        chipSelect_n = 1'b1;
        readWrite = 1'b1;
        address = 15'h0000;
        writeData = 16'h0000;
        faults = 0;
    end

    // One access held until ack; released lines show the inverse so stale data never matches
    task automatic xfer(input logic rd, input logic [14:0] a, input logic [15:0] d, output logic [15:0] q);
        int n;
        n = 0;
        @(posedge clk_sys);
        #5;
        chipSelect_n = 1'b0;
        readWrite = rd;
        address = a;
        writeData = d;
        @(posedge clk_sys);
        while (dataAck_n !== 1'b0 && n < 60) begin
            @(posedge clk_sys);
            n++;
        end
        q = readData;
        #5;
        chipSelect_n = 1'b1;
        address = ~a;
        writeData = ~d;
        while (dataAck_n !== 1'b1 && n < 60) begin
            @(posedge clk_sys);
            n++;
        end
        #5;
        if (n >= 60) begin
            faults++;
        end
    endtask
endmodule
